// ===== rtl/hsiod_decoder.sv
// Host slot I/O decoder: chip selects, sub-slot register, mapper, stand-alone slot selects.
// Assumes host strobes are active high after pin sync; mode and enables are static straps.
//
// Contract
// - Add-on mode: video_display_processor answers ports 98h-9Bh.
// - Upgrade mode: it moves to 88h-8Bh and leaves 98h-9Bh.
// - 4096 KB RAM expansion appears in sub-slot 0 of the board slot.
// - Two async_serial_adapter ports, each enabled separately, disabled after reset.
// - Upgrade mode maps replacement main ROM and extension_rom_image at start-up.
// - Upgrade mode also decodes a clock peripheral and a memory mapper.
// - Enhanced disk OS needs RAM and OS ROM sub-slots, only in unexpanded slot.
// - Stand-alone mode drives slot selects for 3 plain or 12 expanded slots; extSub only follows the sub-slot register, not writable in this mode.
`timescale 1ns/1ps
module hsiod_decoder (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire hsiod_pkg::hsiod_bus_t busPin,
  input  wire logic [1:0]           modeSel,
  input  wire logic                 serAEnable,
  input  wire logic                 serBEnable,
  input  wire logic                 dosEnable,
  input  wire logic                 hostSlotExpanded,
  input  wire logic                 bootDone,
  output hsiod_pkg::hsiod_sel_t     sel,
  output logic                      busDriveEn,
  output logic [7:0]                rdata,
  output logic [7:0]                mapperPage,
  output hsiod_pkg::hsiod_ext_t     extSel,
  output logic                      extSlotActive
);
  // Three-stage sync; the first stage feeds only the second
  hsiod_pkg::hsiod_bus_t s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  hsiod_pkg::hsiod_mode_t mode;
  hsiod_pkg::hsiod_bus_t  b;
  logic [7:0] ssr_q, ssr_d;
  logic [7:0] map_q [4];
  logic [7:0] map_d [4];
  logic       serAEn_q, serAEn_d, serBEn_q, serBEn_d;
  hsiod_pkg::hsiod_sel_t  sel_d;
  logic       drv_d;
  logic [7:0] rdata_d, page_d;
  hsiod_pkg::hsiod_ext_t  ext_d;
  logic       extAct_d;
  logic [7:0] ioAddr;
  logic [1:0] page, sub;
  logic       stable, slotHit;

  always_comb begin
    s1_d = busPin;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Act only once stages two and three agree
  always_comb begin
    stable = (s2_q == s3_q);
    b      = s3_q;
    if (!stable) begin
      b.ioReq  = 1'b0;
      b.memReq = 1'b0;
    end
    ioAddr  = b.addr[7:0];
    page    = b.addr[15:14];
    sub     = ssr_q[2*page +: 2];
    slotHit = b.slotSel && b.memReq;
    unique case (modeSel)
      2'h1:    mode = hsiod_pkg::MODE_UPGRADE;
      2'h2:    mode = hsiod_pkg::MODE_STANDALONE;
      default: mode = hsiod_pkg::MODE_ADDON;
    endcase
  end

  always_comb begin
    ssr_d    = ssr_q;
    map_d    = map_q;
    serAEn_d = serAEnable;
    serBEn_d = serBEnable;
    sel_d    = '0;
    ext_d    = extSel;
    extAct_d = 1'b0;
    if (mode == hsiod_pkg::MODE_UPGRADE) begin
      sel_d.video = b.ioReq &&
                    ((ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_UPG_BASE);
    end else if (mode == hsiod_pkg::MODE_ADDON) begin
      sel_d.video = b.ioReq &&
                    ((ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_STD_BASE);
    end
    sel_d.serA = b.ioReq && serAEn_q &&
                 ((ioAddr & hsiod_pkg::SER_PORT_MASK) == hsiod_pkg::SER_A_BASE);
    sel_d.serB = b.ioReq && serBEn_q &&
                 ((ioAddr & hsiod_pkg::SER_PORT_MASK) == hsiod_pkg::SER_B_BASE);
    if (mode == hsiod_pkg::MODE_UPGRADE) begin
      sel_d.rtc    = b.ioReq && ((ioAddr & hsiod_pkg::RTC_PORT_MASK) == hsiod_pkg::RTC_BASE);
      sel_d.mapper = b.ioReq && ((ioAddr & hsiod_pkg::MAPPER_MASK) == hsiod_pkg::MAPPER_BASE);
      if (sel_d.mapper && b.wr) begin
        map_d[ioAddr[1:0]] = (b.wdata > hsiod_pkg::MAPPER_PAGE_MAX) ?
                             hsiod_pkg::MAPPER_PAGE_MAX : b.wdata;
      end
    end
    // Sub-slot register lives at the top of memory of the board slot
    sel_d.ssr = slotHit && (b.addr == hsiod_pkg::SSR_ADDR) &&
                (mode != hsiod_pkg::MODE_STANDALONE);
    if (sel_d.ssr && b.wr) begin
      ssr_d = b.wdata;
    end
    if (slotHit && !sel_d.ssr && mode != hsiod_pkg::MODE_STANDALONE) begin
      sel_d.ram = (sub == hsiod_pkg::RAM_SUBSLOT);
      // Replacement main ROM only until start-up has finished; extension image stays mapped after it
      sel_d.romImg = (mode == hsiod_pkg::MODE_UPGRADE) && !bootDone &&
                     (sub == hsiod_pkg::ROM_SUBSLOT);
      sel_d.extImg = (mode == hsiod_pkg::MODE_UPGRADE) &&
                     (sub == hsiod_pkg::EXT_SUBSLOT);
      // OS ROM sub-slot needs a non-expanded host slot; the RAM sub-slot decodes in either case
      sel_d.dosRom = dosEnable && !hostSlotExpanded &&
                     (sub == hsiod_pkg::DOS_SUBSLOT);
    end
    if (mode == hsiod_pkg::MODE_STANDALONE && b.memReq) begin
      ext_d.extSlot     = (page == 2'h3) ? 2'h2 : page[0] ? 2'h1 : 2'h0;
      ext_d.extSub      = sub;
      ext_d.extExpanded = hostSlotExpanded;
      extAct_d          = 1'b1;
    end
    page_d = map_q[page];
    drv_d  = b.rd && (sel_d.video || sel_d.serA || sel_d.serB || sel_d.rtc ||
                      sel_d.mapper || sel_d.ssr);
    rdata_d = 8'h00;
    if (sel_d.ssr) begin
      rdata_d = ~ssr_q;
    end else if (sel_d.mapper) begin
      rdata_d = map_q[ioAddr[1:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q          <= '0;
      s2_q          <= '0;
      s3_q          <= '0;
      ssr_q         <= hsiod_pkg::SSR_RESET;
      map_q         <= hsiod_pkg::MAP_RESET;
      serAEn_q      <= 1'b0;
      serBEn_q      <= 1'b0;
      sel           <= '0;
      busDriveEn    <= 1'b0;
      rdata         <= 8'h00;
      mapperPage    <= 8'h00;
      extSel        <= '0;
      extSlotActive <= 1'b0;
    end else begin
      s1_q          <= s1_d;
      s2_q          <= s2_d;
      s3_q          <= s3_d;
      ssr_q         <= ssr_d;
      map_q         <= map_d;
      serAEn_q      <= serAEn_d;
      serBEn_q      <= serBEn_d;
      sel           <= sel_d;
      busDriveEn    <= drv_d;
      rdata         <= rdata_d;
      mapperPage    <= page_d;
      extSel        <= ext_d;
      extSlotActive <= extAct_d;
    end
  end

  AST_STD_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_ADDON && b.ioReq &&
     (ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_STD_BASE) |=> sel.video)
    else $error("Video port not decoded in add-on mode");
  AST_UPG_NO_STD: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_UPGRADE &&
     (ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_STD_BASE) |=> !sel.video)
    else $error("Standard video ports answered in upgrade mode");
  AST_UPG_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_UPGRADE && b.ioReq &&
     (ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_UPG_BASE) |=> sel.video)
    else $error("Moved video ports not decoded");
  AST_ADDON_NO_UPG: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_ADDON &&
     (ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_UPG_BASE) |=> !sel.video)
    else $error("Moved video ports answered in add-on mode");
  AST_RAM_SUB0: assert property (@(posedge clk) disable iff (!reset_n)
    sel.ram |-> $past(sub) == 2'h0)
    else $error("RAM selected outside sub-slot 0");
  AST_SER_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    (!serAEn_q || !$past(serAEnable)) |=> !sel.serA)
    else $error("Disabled serial port selected");
  AST_ROM_UPG: assert property (@(posedge clk) disable iff (!reset_n)
    sel.romImg |-> ($past(mode) == hsiod_pkg::MODE_UPGRADE && !$past(bootDone)))
    else $error("ROM image mapped outside upgrade start-up");
  AST_RTC_UPG: assert property (@(posedge clk) disable iff (!reset_n)
    (sel.rtc || sel.mapper) |-> $past(mode) == hsiod_pkg::MODE_UPGRADE)
    else $error("Clock or mapper decoded outside upgrade mode");
  AST_DOS_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
    sel.dosRom |-> !$past(hostSlotExpanded))
    else $error("OS ROM enabled in expanded slot");
  AST_EXT_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
    extSlotActive |-> extSel.extSlot < hsiod_pkg::EXT_SLOTS_UNEXP)
    else $error("External slot number out of range");
  AST_DRIVE_RD: assert property (@(posedge clk) disable iff (!reset_n)
    busDriveEn |-> $past(b.rd))
    else $error("Bus driven outside a read");
  // A cycle with no strobe must never turn the bus around
  AST_DRIVE_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (!b.ioReq && !b.memReq) |=> !busDriveEn)
    else $error("Bus driven with no request");
  AST_DRIVE_MATCH: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_ADDON && b.ioReq && b.rd &&
     (ioAddr & hsiod_pkg::VIDEO_PORT_MASK) == hsiod_pkg::VIDEO_STD_BASE) |=> busDriveEn)
    else $error("Matching read not driven");
  AST_SER_B_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    !serBEn_q |=> !sel.serB)
    else $error("Disabled second serial port selected");
  // Enables must start off so no serial port fights the host bus
  AST_SER_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (!serAEn_q && !serBEn_q))
    else $error("Serial port enabled after reset");
  AST_ROM_SUB: assert property (@(posedge clk) disable iff (!reset_n)
    sel.romImg |-> $past(sub) == hsiod_pkg::ROM_SUBSLOT)
    else $error("ROM image outside its sub-slot");
  AST_DOS_EN: assert property (@(posedge clk) disable iff (!reset_n)
    sel.dosRom |-> $past(dosEnable))
    else $error("OS ROM selected while disabled");
  AST_ALONE_NO_SLOT: assert property (@(posedge clk) disable iff (!reset_n)
    mode == hsiod_pkg::MODE_STANDALONE |=> (!sel.ram && !sel.ssr))
    else $error("Board slot decoded in stand-alone mode");
  AST_EXT_ACTIVE: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == hsiod_pkg::MODE_STANDALONE && b.memReq) |=> extSlotActive)
    else $error("External slot not selected");
  AST_EXT_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
    mode != hsiod_pkg::MODE_STANDALONE |=> !extSlotActive)
    else $error("External slot selected outside stand-alone mode");
endmodule

// ===== rtl/hsiod_pkg.sv
// Package for the host slot I/O decoder: port ranges, slot map, mode, bus and select types.
// Assumes an 8-bit host bus with separate I/O and memory strobes, sampled on the slot clock.
package hsiod_pkg;
  localparam logic [7:0]  VIDEO_STD_BASE  = 8'h98;
  localparam logic [7:0]  VIDEO_UPG_BASE  = 8'h88;
  localparam logic [7:0]  VIDEO_PORT_MASK = 8'hfc;
  localparam logic [7:0]  SER_A_BASE     = 8'h00;
  localparam logic [7:0]  SER_B_BASE     = 8'he8;
  localparam logic [7:0]  SER_PORT_MASK  = 8'hfe;
  localparam logic [7:0]  RTC_BASE       = 8'hb4;
  localparam logic [7:0]  RTC_PORT_MASK  = 8'hfe;
  localparam logic [7:0]  MAPPER_BASE    = 8'hfc;
  localparam logic [7:0]  MAPPER_MASK    = 8'hfc;
  localparam logic [7:0]  SUBSLOT_REG    = 8'hff;
  localparam logic [1:0]  RAM_SUBSLOT    = 2'h0;
  localparam logic [1:0]  DOS_SUBSLOT    = 2'h3;
  localparam logic [1:0]  ROM_SUBSLOT    = 2'h1;
  localparam logic [1:0]  EXT_SUBSLOT    = 2'h2;
  localparam int          RAM_KBYTES     = 4096;
  localparam int          RAM_PAGES      = RAM_KBYTES / 16;
  localparam logic [7:0]  MAPPER_PAGE_MAX = 8'(RAM_PAGES - 1);
  localparam logic [1:0]  EXT_SLOTS_UNEXP = 2'h3;
  localparam logic [3:0]  EXT_SLOTS_EXP   = 4'hc;
  localparam logic [2:0]  SYNC_STAGES     = 3'h3;
  localparam logic [7:0]  SSR_RESET       = 8'h00;
  localparam logic [15:0] SSR_ADDR        = 16'hffff;
  localparam logic [7:0]  MAP_RESET [4]   = '{8'h03, 8'h02, 8'h01, 8'h00};

  typedef enum logic [1:0] {MODE_ADDON, MODE_UPGRADE, MODE_STANDALONE} hsiod_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        ioReq;
    logic        memReq;
    logic        rd;
    logic        wr;
    logic        slotSel;
    logic [7:0]  wdata;
  } hsiod_bus_t;

  typedef struct packed {
    logic        video;
    logic        serA;
    logic        serB;
    logic        rtc;
    logic        mapper;
    logic        ram;
    logic        romImg;
    logic        extImg;
    logic        dosRom;
    logic        ssr;
  } hsiod_sel_t;

  typedef struct packed {
    logic [1:0] extSlot;
    logic [1:0] extSub;
    logic       extExpanded;
  } hsiod_ext_t;
endpackage

// ===== tb/hsiod_host_cpu.sv
// Host CPU model on the cartridge slot: drives whole bus cycles onto the pins.
// Assumes the decoder syncs the pins on clk and answers four edges later.
`timescale 1ns/1ps
module hsiod_host_cpu (
  input  wire logic             clk,
  output hsiod_pkg::hsiod_bus_t busPin
);
  initial busPin = '0;
  // Holds every qualifier six edges so the sync chain and output stage settle
  task automatic drive(input logic [15:0] a, input logic io, input logic rd,
                       input logic [7:0] wd);
    hsiod_pkg::hsiod_bus_t b;
    b = '{addr: a, ioReq: io, memReq: !io, rd: rd, wr: !rd, slotSel: !io, wdata: wd};
    @(posedge clk);
    busPin <= b;
    repeat (6) @(posedge clk);
  endtask
  // Released address and data lines show the inverse of the last value; strobes go to zero
  task automatic idle();
    hsiod_pkg::hsiod_bus_t b;
    b = '{addr: ~busPin.addr, ioReq: 1'b0, memReq: 1'b0, rd: 1'b0, wr: 1'b0,
          slotSel: 1'b0, wdata: ~busPin.wdata};
    @(posedge clk);
    busPin <= b;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ===== tb/host_slot_io_decoder_bench.sv
// Bench for the host slot I/O decoder: bus cycles from the host CPU model.
// Assumes the four-edge answer latency and static mode straps.
`timescale 1ns/1ps
module host_slot_io_decoder_bench;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [1:0]            modeSel = 2'h0;
  logic                  serAEnable = 1'b0;
  logic                  serBEnable = 1'b0;
  logic                  dosEnable = 1'b0;
  logic                  hostSlotExpanded = 1'b0;
  logic                  bootDone = 1'b0;
  hsiod_pkg::hsiod_bus_t busPin;
  hsiod_pkg::hsiod_sel_t sel;
  logic                  busDriveEn;
  hsiod_pkg::hsiod_ext_t extSel;
  logic                  extSlotActive;
  int                    errors = 0;
  int                    checked = 0;
  logic [11:0]           expQ[$];
  event                  seen;

  always #5 clk = ~clk;

  hsiod_host_cpu cpu (.clk(clk), .busPin(busPin));
  hsiod_decoder dut (.clk(clk), .reset_n(reset_n), .busPin(busPin), .modeSel(modeSel),
    .serAEnable(serAEnable), .serBEnable(serBEnable), .dosEnable(dosEnable),
    .hostSlotExpanded(hostSlotExpanded), .bootDone(bootDone), .sel(sel),
    .busDriveEn(busDriveEn), .rdata(), .mapperPage(), .extSel(extSel),
    .extSlotActive(extSlotActive));

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: selects %b expected %b", $time, got, exp);
    end
  endtask

  // Expectation order: video, serA, serB, rtc, ram, drive enable,
  // romImg, extImg, dosRom, external slot active, external slot number
  always @(seen) check({sel.video, sel.serA, sel.serB, sel.rtc, sel.ram, busDriveEn,
                        sel.romImg, sel.extImg, sel.dosRom, extSlotActive, extSel.extSlot},
                       expQ.pop_front());

  task automatic xfer(input logic [7:0] lo, input logic io, input logic rd,
                      input logic [5:0] exp);
    expQ.push_back({exp, 6'h00});
    // Random upper byte must not matter to I/O decode
    cpu.drive({8'($urandom), lo}, io, rd, 8'($urandom));
    #1 ->seen;
    cpu.idle();
  endtask

  // Memory cycle in the board slot at a fixed address
  task automatic mem_xfer(input logic [15:0] a, input logic rd, input logic [7:0] wd,
                          input logic [11:0] exp);
    expQ.push_back(exp);
    cpu.drive(a, 1'b0, rd, wd);
    #1 ->seen;
    cpu.idle();
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    modeSel <= m;
    repeat (4) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(37));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) xfer(8'h98 + 8'(i), 1'b1, 1'b1, 6'b100001);
    xfer(8'h9c, 1'b1, 1'b1, 6'b000000);
    xfer(8'h98, 1'b1, 1'b0, 6'b100000);
    xfer(8'h88, 1'b1, 1'b1, 6'b000000);
    xfer(8'h00, 1'b1, 1'b1, 6'b000000);
    xfer(8'he8, 1'b1, 1'b1, 6'b000000);
    xfer(8'h00, 1'b0, 1'b0, 6'b000010);
    $display("Test add-on decode done");
    set_mode(2'h1);
    xfer(8'h88, 1'b1, 1'b1, 6'b100001);
    xfer(8'h8b, 1'b1, 1'b1, 6'b100001);
    xfer(8'h98, 1'b1, 1'b1, 6'b000000);
    xfer(8'hb4, 1'b1, 1'b1, 6'b000101);
    mem_xfer(16'hffff, 1'b0, 8'h55, 12'h000);
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'b000000_100000);
    bootDone <= 1'b1;
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'h000);
    mem_xfer(16'hffff, 1'b0, 8'haa, 12'h000);
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'b000000_010000);
    mem_xfer(16'hffff, 1'b0, 8'hff, 12'h000);
    dosEnable <= 1'b1;
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'b000000_001000);
    hostSlotExpanded <= 1'b1;
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'h000);
    $display("Test upgrade decode done");
    set_mode(2'h0);
    serAEnable <= 1'b1;
    serBEnable <= 1'b1;
    xfer(8'h01, 1'b1, 1'b1, 6'b010001);
    xfer(8'he8, 1'b1, 1'b1, 6'b001001);
    $display("Test serial enables done");
    set_mode(2'h2);
    mem_xfer(16'hc000, 1'b1, 8'h00, 12'b000000_000110);
    mem_xfer(16'h4000, 1'b1, 8'h00, 12'b000000_000101);
    $display("Test stand-alone slots done");
    give_verdict();
  end
endmodule
